// ---- src/dma_geom_pkg.sv ----
// Constants for one DMA channel: status flags, geometry registers, state codes.
// Assumes a single 50 MHz clock and a plain strobe register port.
// Operation
// [R01] Set dst_done_flag when destination pointer reaches dst_size.
// [R02] Set dst_half_flag when destination pointer reaches half dst_size.
// [R03] Set block_done_flag when larger size moved, or on pattern match.
// [R04] Set cell_done_flag after each cell of cell_size bytes completes.
// [R05] Abort transfer on matching abort interrupt and set abort_flag.
// [R06] Set addr_error_flag on invalid source or destination address.
// [R07] Software writes a physical source start address.
// [R08] Software writes a physical destination start address.
// [R09] Source size N means N bytes; zero means 65536.
// [R10] Destination size N means N bytes; zero means 65536.
// [R11] Size register bits above sixteen read zero, ignore writes.
// [R12] Flags reset to zero; address and size registers reset zero.
// [R13] Source done and half flags follow source pointer against src_size.
// [R14] Enable bits in byte two permit each flag's interrupt.
// [R15] Interrupt high while any enabled flag set; flags sticky until cleared.
// [R16] Address and size registers are read/write, reset to zero.
package dma_geom_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_INT  = 8'h00;
  localparam logic [7:0] OFS_SSA  = 8'h04;
  localparam logic [7:0] OFS_DSA  = 8'h08;
  localparam logic [7:0] OFS_SSIZ = 8'h0c;
  localparam logic [7:0] OFS_DSIZ = 8'h10;
  localparam logic [7:0] OFS_CSIZ = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_SPTR = 8'h1c;
  localparam logic [7:0] OFS_DPTR = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLAG_LSB   = 0;
  localparam int ENABLE_LSB = 16;
  localparam int BIT_ERR    = 0;
  localparam int BIT_ABORT  = 1;
  localparam int BIT_CELL   = 2;
  localparam int BIT_BLOCK  = 3;
  localparam int BIT_DHALF  = 4;
  localparam int BIT_DDONE  = 5;
  localparam int BIT_SHALF  = 6;
  localparam int BIT_SDONE  = 7;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_AIRQEN = 1;
  localparam int CTRL_AIRQ_LSB = 8;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [16:0] SIZE_ZERO_BYTES = 17'h1_0000;
  localparam logic [31:0] ADDR_LIMIT  = 32'h2000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_WAIT = 2'b11
  } chan_state_t;

endpackage : dma_geom_pkg

// ---- src/size_decode.sv ----
// Expands a 16-bit size field into a 17-bit byte count.
// Assumes purely combinational use inside the channel.
`timescale 1ns/10ps
`default_nettype none
module size_decode
  import dma_geom_pkg::*;
(
  // Field
  input  wire logic [15:0] sizeField,
  // Count
  output logic      [16:0] byteCount
);
  assign byteCount = (sizeField == 16'h0000) ? SIZE_ZERO_BYTES : {1'b0, sizeField};
endmodule : size_decode
`default_nettype wire

// ---- src/reset_sync.sv ----
// Two-stage release of the asynchronous active-low reset.
// Assumes clk runs continuously.
`timescale 1ns/10ps
`default_nettype none
module reset_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Synchronised reset
  output logic      rstSyncN
);
  logic stage1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1   <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      stage1   <= 1'b1;
      rstSyncN <= stage1;
    end
  end
endmodule : reset_sync
`default_nettype wire

// ---- src/dma_channel_status_and_geometry.sv ----
// One DMA channel: geometry registers, byte mover, status flags, interrupt.
// Assumes a plain strobe register port and one byte moved per acknowledged bus beat.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_status_and_geometry
  import dma_geom_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Events from the system
  input  wire logic        startTrig,
  input  wire logic [7:0]  irqNum,
  input  wire logic        irqValid,
  input  wire logic        patternMatch,
  // Memory bus
  output logic [31:0]      busRdAddr,
  output logic [31:0]      busWrAddr,
  output logic             busXfer,
  input  wire logic        busAck,
  // Interrupt
  output logic             chanIrq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstN;
  reset_sync uRst (
    .clk      (clk),
    .resetn   (resetn),
    .rstSyncN (rstN)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] srcStart_r;
  logic [31:0] dstStart_r;
  logic [15:0] srcSize_r;
  logic [15:0] dstSize_r;
  logic [15:0] cellSize_r;
  logic [7:0]  flags_r;
  logic [7:0]  enables_r;
  logic        chanEn_r;
  logic        abortIrqEn_r;
  logic [7:0]  abortIrqSel_r;
  logic [15:0] srcPointer_r;
  logic [15:0] dstPointer_r;
  logic [16:0] cellCount_r;
  logic [16:0] blockCount_r;
  chan_state_t state_r;

  logic wrInt;
  logic wrSsa;
  logic wrDsa;
  logic wrSsiz;
  logic wrDsiz;
  logic wrCsiz;
  logic wrCtrl;
  assign wrInt  = regWrite && (regAddr == OFS_INT);
  assign wrSsa  = regWrite && (regAddr == OFS_SSA);
  assign wrDsa  = regWrite && (regAddr == OFS_DSA);
  assign wrSsiz = regWrite && (regAddr == OFS_SSIZ);
  assign wrDsiz = regWrite && (regAddr == OFS_DSIZ);
  assign wrCsiz = regWrite && (regAddr == OFS_CSIZ);
  assign wrCtrl = regWrite && (regAddr == OFS_CTRL);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      srcStart_r <= RESET_WORD; // R12
      dstStart_r <= RESET_WORD;
      srcSize_r  <= 16'h0000;
      dstSize_r  <= 16'h0000;
      cellSize_r <= 16'h0000;
    end else begin
      if (wrSsa) srcStart_r <= regWdata; // R16
      if (wrDsa) dstStart_r <= regWdata;
      if (wrSsiz) srcSize_r <= regWdata[15:0]; // R11
      if (wrDsiz) dstSize_r <= regWdata[15:0];
      if (wrCsiz) cellSize_r <= regWdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      enables_r     <= 8'h00;
      abortIrqEn_r  <= 1'b0;
      abortIrqSel_r <= 8'h00;
    end else begin
      if (wrInt) enables_r <= regWdata[ENABLE_LSB +: 8]; // R14
      if (wrCtrl) begin
        abortIrqEn_r  <= regWdata[CTRL_AIRQEN];
        abortIrqSel_r <= regWdata[CTRL_AIRQ_LSB +: 8];
      end
    end
  end

  // ----------------------------------------
  // Size decode
  // ----------------------------------------
  logic [16:0] srcBytes;
  logic [16:0] dstBytes;
  logic [16:0] cellBytes;
  logic [16:0] blockBytes;
  size_decode uSrc (.sizeField(srcSize_r), .byteCount(srcBytes)); // R09
  size_decode uDst (.sizeField(dstSize_r), .byteCount(dstBytes)); // R10
  size_decode uCel (.sizeField(cellSize_r), .byteCount(cellBytes));
  assign blockBytes = (srcBytes > dstBytes) ? srcBytes : dstBytes;

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  logic abortHit;
  logic addrBad;
  logic beat;
  logic [16:0] srcNext;
  logic [16:0] dstNext;
  logic cellEnd;
  logic blockEnd;
  assign abortHit = abortIrqEn_r && irqValid && (irqNum == abortIrqSel_r); // R05
  assign addrBad  = (srcStart_r >= ADDR_LIMIT) || (dstStart_r >= ADDR_LIMIT); // R06
  assign beat     = (state_r == ST_MOVE) && busAck;
  assign srcNext  = {1'b0, srcPointer_r} + 17'h0_0001;
  assign dstNext  = {1'b0, dstPointer_r} + 17'h0_0001;
  assign cellEnd  = beat && ((cellCount_r + 17'h0_0001) == cellBytes);
  assign blockEnd = beat && ((blockCount_r + 17'h0_0001) == blockBytes);

  logic startOk;
  assign startOk = chanEn_r && startTrig && !addrBad;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (startOk && !abortHit && !patternMatch) state_r <= ST_MOVE;
        end
        ST_MOVE: begin
          if (abortHit || patternMatch || blockEnd || cellEnd) state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      chanEn_r <= 1'b0;
    end else if (abortHit || patternMatch || blockEnd) begin
      chanEn_r <= 1'b0; // R05
    end else if (wrCtrl) begin
      chanEn_r <= regWdata[CTRL_EN];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      srcPointer_r <= 16'h0000;
      dstPointer_r <= 16'h0000;
      blockCount_r <= 17'h0_0000;
    end else if (abortHit || patternMatch || blockEnd || (wrCtrl && regWdata[CTRL_EN])) begin
      srcPointer_r <= 16'h0000;
      dstPointer_r <= 16'h0000;
      blockCount_r <= 17'h0_0000;
    end else if (beat) begin
      srcPointer_r <= (srcNext == srcBytes) ? 16'h0000 : srcNext[15:0];
      dstPointer_r <= (dstNext == dstBytes) ? 16'h0000 : dstNext[15:0];
      blockCount_r <= blockCount_r + 17'h0_0001;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cellCount_r <= 17'h0_0000;
    end else if (state_r == ST_IDLE || cellEnd || abortHit) begin
      cellCount_r <= 17'h0_0000;
    end else if (beat) begin
      cellCount_r <= cellCount_r + 17'h0_0001;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busRdAddr <= RESET_WORD;
      busWrAddr <= RESET_WORD;
      busXfer   <= 1'b0;
    end else begin
      busRdAddr <= srcStart_r + {16'h0000, srcPointer_r};
      busWrAddr <= dstStart_r + {16'h0000, dstPointer_r};
      busXfer   <= (state_r == ST_MOVE) && !abortHit && !patternMatch && !beat;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic [7:0] flagSet;
  always_comb begin
    flagSet            = 8'h00;
    flagSet[BIT_SDONE] = beat && (srcNext == srcBytes); // R13
    flagSet[BIT_SHALF] = beat && (srcNext == {1'b0, srcBytes[16:1]}); // R13
    flagSet[BIT_DDONE] = beat && (dstNext == dstBytes); // R01
    flagSet[BIT_DHALF] = beat && (dstNext == {1'b0, dstBytes[16:1]}); // R02
    flagSet[BIT_BLOCK] = blockEnd || patternMatch; // R03
    flagSet[BIT_CELL]  = cellEnd; // R04
    flagSet[BIT_ABORT] = abortHit && (state_r != ST_IDLE); // R05
    flagSet[BIT_ERR]   = chanEn_r && startTrig && addrBad; // R06
  end

  logic [7:0] flagClr;
  assign flagClr = wrInt ? regWdata[FLAG_LSB +: 8] : 8'h00;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flags_r <= 8'h00; // R12
    end else begin
      flags_r <= (flags_r & ~flagClr) | flagSet; // R15
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      chanIrq <= 1'b0;
    end else begin
      chanIrq <= |(((flags_r & ~flagClr) | flagSet) & enables_r); // R15
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= RESET_WORD;
    end else if (regRead) begin
      unique case (regAddr)
        OFS_INT:  regRdata <= {8'h00, enables_r, 8'h00, flags_r};
        OFS_SSA:  regRdata <= srcStart_r;
        OFS_DSA:  regRdata <= dstStart_r;
        OFS_SSIZ: regRdata <= {16'h0000, srcSize_r}; // R11
        OFS_DSIZ: regRdata <= {16'h0000, dstSize_r};
        OFS_CSIZ: regRdata <= {16'h0000, cellSize_r};
        OFS_CTRL: regRdata <= {16'h0000, abortIrqSel_r, 6'h00, abortIrqEn_r, chanEn_r};
        OFS_SPTR: regRdata <= {16'h0000, srcPointer_r};
        OFS_DPTR: regRdata <= {16'h0000, dstPointer_r};
        OFS_STAT: regRdata <= {30'h0000_0000, state_r};
        default:  regRdata <= RESET_WORD;
      endcase
    end else begin
      regRdata <= RESET_WORD;
    end
  end

endmodule : dma_channel_status_and_geometry
`default_nettype wire

// ---- verif/bus_responder.sv ----
// Memory side of the channel: acknowledges each byte beat.
// Assumes busXfer holds until the beat after busAck.
`timescale 1ns/10ps
`default_nettype none
module bus_responder (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Beat handshake
  input  wire logic busXfer,
  input  wire logic slow,
  output logic      busAck
);
  logic [1:0] waitCnt_r;

  // Prompt or four-cycle slow answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitCnt_r <= 2'h0;
      busAck    <= 1'b0;
    end else if (busXfer && !busAck) begin
      waitCnt_r <= waitCnt_r + 2'h1;
      busAck    <= !slow || waitCnt_r == 2'h3;
    end else begin
      waitCnt_r <= 2'h0;
      busAck    <= 1'b0;
    end
  end
endmodule : bus_responder
`default_nettype wire

// ---- verif/dma_channel_status_and_geometry_properties.sv ----
// Port checker for the DMA channel.
// Assumes the channel top ports and its package.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_checker
  import dma_geom_pkg::*;
(
  // Watched ports
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        irqValid,
  input wire logic        patternMatch,
  input wire logic [31:0] busRdAddr,
  input wire logic [31:0] busWrAddr,
  input wire logic        busXfer,
  input wire logic        busAck,
  input wire logic        chanIrq
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_SIZE_UPPER: assert property (regRead && (regAddr == OFS_SSIZ
    || regAddr == OFS_DSIZ) |=> regRdata[31:16] == 16'h0) else $error("size upper bits set");
  AST_INT_GAPS: assert property (regRead && regAddr == OFS_INT
    |=> regRdata[15:8] == 8'h0 && regRdata[31:24] == 8'h0) else $error("flag gaps set");
  AST_IRQ_MATCH: assert property (regRead && regAddr == OFS_INT
    |=> chanIrq == |(regRdata[7:0] & regRdata[23:16])) else $error("irq not flag and enable");
  AST_ADDR_VALID: assert property (busXfer |-> busRdAddr < ADDR_LIMIT
    && busWrAddr < ADDR_LIMIT) else $error("beat on invalid address");
  AST_BEAT_END: assert property (busXfer && busAck |=> !busXfer)
    else $error("beat request stayed after ack");
  AST_BEAT_HOLD: assert property (busXfer && !busAck && !irqValid
    && !patternMatch && !$past(regWrite) |=> busXfer && $stable(busRdAddr)
    && $stable(busWrAddr)) else $error("beat request dropped early");
  AST_PATTERN_STOP: assert property (patternMatch && busXfer |=> !busXfer [*3])
    else $error("transfer went on after pattern match");
  AST_IRQ_MASKED: assert property (regWrite && regAddr == OFS_INT
    && regWdata[23:16] == 8'h0 |-> ##2 !chanIrq) else $error("masked irq high");

  COV_BEAT: cover property (busXfer && busAck);
  COV_PATTERN: cover property (patternMatch && busXfer);
  COV_IRQ: cover property (chanIrq);
endmodule : dma_channel_checker
`default_nettype wire

bind dma_channel_status_and_geometry dma_channel_checker dma_channel_checker_i (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irqValid(irqValid),
  .patternMatch(patternMatch), .busRdAddr(busRdAddr), .busWrAddr(busWrAddr),
  .busXfer(busXfer), .busAck(busAck), .chanIrq(chanIrq));

// ---- verif/dma_channel_status_and_geometry_bench.sv ----
// Register-level bench for the DMA channel.
// Assumes the bus responder on the memory side.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_status_and_geometry_bench
  import dma_geom_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        regWrite, regRead, startTrig, irqValid, patternMatch, slowBus;
  logic        busXfer, busAck, chanIrq;
  logic [7:0]  regAddr, irqNum;
  logic [31:0] regWdata, regRdata, busRdAddr, busWrAddr, v, lastRd, lastWr;
  int          fails = 0;
  int          samplesChecked = 0;

  always #10 clk = ~clk;

  dma_channel_status_and_geometry dma_channel_status_and_geometry_i (.clk(clk),
    .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .startTrig(startTrig), .irqNum(irqNum),
    .irqValid(irqValid), .patternMatch(patternMatch), .busRdAddr(busRdAddr),
    .busWrAddr(busWrAddr), .busXfer(busXfer), .busAck(busAck), .chanIrq(chanIrq));
  bus_responder bus_responder_i (.clk(clk), .resetn(resetn), .busXfer(busXfer),
    .slow(slowBus), .busAck(busAck));

  // Addresses of the last acknowledged beat
  always @(posedge clk) begin
    if (busXfer && busAck) begin
      lastRd <= busRdAddr;
      lastWr <= busWrAddr;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rdchk

  task automatic trig();
    @(posedge clk);
    startTrig <= 1'b1;
    @(posedge clk);
    startTrig <= 1'b0;
  endtask : trig

  task automatic settle();
    for (int i = 0; i < 80; i++) begin
      rd(OFS_STAT);
      if (v === 32'h0) break;
    end
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {regWrite, regRead, startTrig, irqValid, patternMatch, slowBus} = 6'h0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    irqNum = 8'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 16; a += 4) rdchk(8'(a), 32'h0);
    rdchk(8'h40, 32'h0);
    wr(OFS_SSA, 32'hdead_beef);
    rdchk(OFS_SSA, 32'hdead_beef);
    wr(OFS_DSA, 32'h1fff_fffe);
    rdchk(OFS_DSA, 32'h1fff_fffe);
    wr(OFS_SSIZ, 32'hffff_0004);
    rdchk(OFS_SSIZ, 32'h0000_0004);
    wr(OFS_DSIZ, 32'hffff_0002);
    rdchk(OFS_DSIZ, 32'h0000_0002);
    wr(OFS_CSIZ, 32'h0000_0002);
    rdchk(OFS_CSIZ, 32'h0000_0002);
    wr(OFS_INT, 32'h00ff_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    trig();
    settle();
    rdchk(OFS_INT, 32'h00ff_0001);
    chk({31'h0, chanIrq}, 32'h1);
    wr(OFS_INT, 32'h0000_00ff);
    rdchk(OFS_INT, 32'h0);
    wr(OFS_SSA, 32'h0000_0100);
    wr(OFS_INT, 32'h00ff_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    trig();
    settle();
    rdchk(OFS_INT, 32'h00ff_0074);
    chk(lastRd, 32'h0000_0101);
    chk(lastWr, 32'h1fff_ffff);
    rdchk(OFS_SPTR, 32'h0000_0002);
    wr(OFS_INT, 32'h00ff_00ff);
    rdchk(OFS_INT, 32'h00ff_0000);
    slowBus <= 1'b1;
    trig();
    settle();
    rdchk(OFS_INT, 32'h00ff_00bc);
    chk(lastRd, 32'h0000_0103);
    rdchk(OFS_CTRL, 32'h0000_0000);
    wr(OFS_INT, 32'h0000_00ff);
    wr(OFS_SSIZ, 32'h0000_0010);
    wr(OFS_DSIZ, 32'h0000_0010);
    wr(OFS_CSIZ, 32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_2a03);
    trig();
    @(posedge clk);
    irqNum   <= 8'h2b;
    irqValid <= 1'b1;
    @(posedge clk);
    irqNum   <= 8'h2a;
    @(posedge clk);
    irqValid <= 1'b0;
    settle();
    rdchk(OFS_INT, 32'h0000_0002);
    chk({31'h0, chanIrq}, 32'h0);
    wr(OFS_INT, 32'h0002_0000);
    rdchk(OFS_INT, 32'h0002_0002);
    chk({31'h0, chanIrq}, 32'h1);
    wr(OFS_INT, 32'h0000_00ff);
    wr(OFS_CTRL, 32'h0000_0001);
    trig();
    @(posedge clk);
    patternMatch <= 1'b1;
    @(posedge clk);
    patternMatch <= 1'b0;
    settle();
    rdchk(OFS_INT, 32'h0000_0008);
    give_verdict();
  end

  initial begin
    #(20 * 20000);
    fails++;
    give_verdict();
  end
endmodule : dma_channel_status_and_geometry_bench
`default_nettype wire
